// file: rtl/sprsc_pkg.sv
package sprsc_pkg;

    // ******************************************************
    // register offsets
    // ******************************************************
    localparam logic [11:0] READBACK_DRIVER_CTRL_ADDR = 12'h054;
    localparam logic [11:0] PULSE_BURST_MODE_ADDR     = 12'h05A;
    localparam logic [11:0] EXT_SYNC_CTRL_ADDR        = 12'h05B;
    localparam logic [11:0] MASTER_TIMER_LOW_ADDR     = 12'h05C;
    localparam logic [11:0] MASTER_TIMER_HIGH_ADDR    = 12'h05D;
    localparam logic [11:0] INPUT_CLOCK_CTRL_ADDR     = 12'h064;
    localparam logic [11:0] DELAY_POWER_CTRL_ADDR     = 12'h065;

    // ******************************************************
    // field positions
    // ******************************************************
    localparam int READBACK_ENABLE_BIT = 0;  // driver enable
    localparam int READBACK_MODE_BIT   = 1;  // 0 open drain, 1 push pull
    localparam int SYNC_POLARITY_BIT   = 0;  // 0 positive, 1 negative
    localparam int SYNC_RETIME_BIT     = 2;  // 1 retime on beat
    localparam int LOW_FREQ_BIAS_BIT   = 0;  // class a bias
    localparam int INPUT_DIV2_BIT      = 1;  // divide by two
    localparam int DELAY_LOW_POWER_BIT = 0;  // analog delay low power

    // ******************************************************
    // reset values and encodings
    // ******************************************************
    localparam logic [7:0]  REG_RESET_VALUE    = 8'h00;
    localparam logic [11:0] TIMER_RESET_VALUE  = 12'h000;
    localparam logic [3:0]  PIN_FUNC_PULSE_REQ = 4'h4;
    localparam logic [2:0]  MODE_LEVEL         = 3'h0;
    localparam logic [2:0]  MODE_CONTINUOUS    = 3'h7;

    // pulse generator states
    typedef enum logic [1:0] {
        SPRSC_IDLE = 2'b00,
        SPRSC_HIGH = 2'b01,
        SPRSC_LOW  = 2'b10
    } sprsc_state_type;

    // pulse count of a counted burst mode
    function automatic logic [4:0] burst_len(input logic [2:0] mode);
        case (mode)
            3'h1:    burst_len = 5'h01;
            3'h2:    burst_len = 5'h02;
            3'h3:    burst_len = 5'h04;
            3'h4:    burst_len = 5'h08;
            3'h5:    burst_len = 5'h10;
            3'h6:    burst_len = 5'h10;
            default: burst_len = 5'h00;
        endcase
    endfunction : burst_len

endpackage : sprsc_pkg

// file: rtl/sprsc_core.sv
// Overview of operation
// - readback bit1 driver type, bit0 enable
// - mode 000 runs while request present
// - counted burst of 1,2,4,8,16 pulses
// - mode 111 continuous 50 percent pulses
// - sync bit2 retimes sync to beat
// - sync bit0 selects polarity, normally 0
// - 12-bit timer setpoint sets beat rate
// - input bit1 inserts divide by two
// - delay bit0 enables low power mode
// - input pin function 0100 requests pulses
`timescale 1ns/10ps
`default_nettype none

module sprsc_core #(
    parameter int ADDR_WIDTH = 12
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [ADDR_WIDTH-1:0] reg_addr,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    input  wire logic [7:0]            reg_wdata,
    output var  logic [7:0]            reg_rdata,
    output var  logic                  reg_rvalid,
    input  wire logic                  readback_active,
    input  wire logic                  readback_bit,
    output var  logic                  serial_readback_line_out,
    output var  logic                  serial_readback_line_oe,
    input  wire logic                  general_input_pin,
    input  wire logic [3:0]            input_pin_function_field,
    input  wire logic                  serial_pulse_request,
    input  wire logic                  sync_pin,
    output var  logic                  sysref_out,
    output var  logic                  pulse_request_status,
    output var  logic                  input_div2_enable,
    output var  logic                  low_freq_bias,
    output var  logic                  analog_delay_low_power
);

    // ******************************************************
    // elaboration check
    // ******************************************************
    if (ADDR_WIDTH < 7 || ADDR_WIDTH > 12) begin : g_bad_width
        $error("ADDR_WIDTH must lie between 7 and 12");
    end

    // ******************************************************
    // register file
    // ******************************************************
    logic [1:0]  readback_ctrl;       // mode and enable
    logic [2:0]  pulse_mode;          // pulse generator mode
    logic [2:0]  sync_ctrl;           // retime, reserved, polarity
    logic [11:0] timer_setpoint;      // master timer setpoint
    logic [1:0]  clock_ctrl;          // divide and bias
    logic [1:0]  next_readback_ctrl;
    logic [2:0]  next_pulse_mode;
    logic [2:0]  next_sync_ctrl;
    logic [11:0] next_timer_setpoint;
    logic [1:0]  next_clock_ctrl;
    logic        next_low_power;
    logic [7:0]  next_rdata;
    logic [11:0] addr;                // address widened to full map

    assign addr = 12'(reg_addr);

    // decode writes and reads
    always_comb begin
        next_readback_ctrl  = readback_ctrl;
        next_pulse_mode     = pulse_mode;
        next_sync_ctrl      = sync_ctrl;
        next_timer_setpoint = timer_setpoint;
        next_clock_ctrl     = clock_ctrl;
        next_low_power      = analog_delay_low_power;
        next_rdata          = reg_rdata;
        if (reg_write) begin
            case (addr)
                sprsc_pkg::READBACK_DRIVER_CTRL_ADDR: begin
                    next_readback_ctrl = reg_wdata[1:0];
                end
                sprsc_pkg::PULSE_BURST_MODE_ADDR: begin
                    next_pulse_mode = reg_wdata[2:0];
                end
                sprsc_pkg::EXT_SYNC_CTRL_ADDR: begin
                    next_sync_ctrl = {reg_wdata[2], 1'b0, reg_wdata[0]};
                end
                sprsc_pkg::MASTER_TIMER_LOW_ADDR: begin
                    next_timer_setpoint[7:0] = reg_wdata;
                end
                sprsc_pkg::MASTER_TIMER_HIGH_ADDR: begin
                    next_timer_setpoint[11:8] = reg_wdata[3:0];
                end
                sprsc_pkg::INPUT_CLOCK_CTRL_ADDR: begin
                    next_clock_ctrl = reg_wdata[1:0];
                end
                sprsc_pkg::DELAY_POWER_CTRL_ADDR: begin
                    next_low_power = reg_wdata[0];
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
        if (reg_read) begin
            case (addr)
                sprsc_pkg::READBACK_DRIVER_CTRL_ADDR:
                    next_rdata = {6'h00, readback_ctrl};
                sprsc_pkg::PULSE_BURST_MODE_ADDR:
                    next_rdata = {5'h00, pulse_mode};
                sprsc_pkg::EXT_SYNC_CTRL_ADDR:
                    next_rdata = {5'h00, sync_ctrl};
                sprsc_pkg::MASTER_TIMER_LOW_ADDR:
                    next_rdata = timer_setpoint[7:0];
                sprsc_pkg::MASTER_TIMER_HIGH_ADDR:
                    next_rdata = {4'h0, timer_setpoint[11:8]};
                sprsc_pkg::INPUT_CLOCK_CTRL_ADDR:
                    next_rdata = {6'h00, clock_ctrl};
                sprsc_pkg::DELAY_POWER_CTRL_ADDR:
                    next_rdata = {7'h00, analog_delay_low_power};
                default:
                    next_rdata = 8'h00;
            endcase
        end
    end

    // register storage
    always_ff @(posedge clk) begin
        if (reset) begin
            readback_ctrl          <= sprsc_pkg::REG_RESET_VALUE[1:0];
            pulse_mode             <= sprsc_pkg::REG_RESET_VALUE[2:0];
            sync_ctrl              <= sprsc_pkg::REG_RESET_VALUE[2:0];
            timer_setpoint         <= sprsc_pkg::TIMER_RESET_VALUE;
            clock_ctrl             <= sprsc_pkg::REG_RESET_VALUE[1:0];
            analog_delay_low_power <= 1'b0;
            reg_rdata              <= 8'h00;
            reg_rvalid             <= 1'b0;
        end else begin
            readback_ctrl          <= next_readback_ctrl;
            pulse_mode             <= next_pulse_mode;
            sync_ctrl              <= next_sync_ctrl;
            timer_setpoint         <= next_timer_setpoint;
            clock_ctrl             <= next_clock_ctrl;
            analog_delay_low_power <= next_low_power;
            reg_rdata              <= next_rdata;
            reg_rvalid             <= reg_read;
        end
    end

    // ******************************************************
    // readback driver and clock path
    // ******************************************************
    logic next_line_out;   // pin level
    logic next_line_oe;    // pin enable
    logic div_phase;       // divide by two phase
    logic tick;            // one distribution clock step

    always_comb begin
        next_line_oe  = 1'b0;
        next_line_out = 1'b0;
        if (readback_active
            && readback_ctrl[sprsc_pkg::READBACK_ENABLE_BIT]) begin
            if (readback_ctrl[sprsc_pkg::READBACK_MODE_BIT]) begin
                next_line_oe  = 1'b1;
                next_line_out = readback_bit;
            end else begin
                next_line_oe  = !readback_bit;
            end
        end
    end

    assign tick = !clock_ctrl[sprsc_pkg::INPUT_DIV2_BIT] || div_phase;

    // driver pin and divider flops
    always_ff @(posedge clk) begin
        if (reset) begin
            serial_readback_line_out <= 1'b0;
            serial_readback_line_oe  <= 1'b0;
            div_phase                <= 1'b0;
            input_div2_enable        <= 1'b0;
            low_freq_bias            <= 1'b0;
        end else begin
            serial_readback_line_out <= next_line_out;
            serial_readback_line_oe  <= next_line_oe;
            div_phase                <= !div_phase;
            input_div2_enable <= clock_ctrl[sprsc_pkg::INPUT_DIV2_BIT];
            low_freq_bias     <= clock_ctrl[sprsc_pkg::LOW_FREQ_BIAS_BIT];
        end
    end

    // ******************************************************
    // master timer and request sources
    // ******************************************************
    logic [11:0] timer_cnt;       // beat down counter
    logic [11:0] next_timer_cnt;
    logic        beat;            // one beat of the master timer
    logic        sync_level;      // polarity corrected sync
    logic        sync_retimed;    // sync held to the beat
    logic        next_sync_retimed;
    logic        sync_eff;        // sync as seen by generator
    logic        next_req;

    assign beat = tick && (timer_cnt == 12'h000);

    always_comb begin
        next_timer_cnt = timer_cnt;
        if (beat) begin
            next_timer_cnt = timer_setpoint;
        end else if (tick) begin
            next_timer_cnt = timer_cnt - 12'h001;
        end
    end

    always_comb begin
        next_sync_retimed = beat ? sync_level : sync_retimed;
        sync_eff = sync_ctrl[sprsc_pkg::SYNC_RETIME_BIT]
                 ? sync_retimed : sync_level;
    end

    assign next_req = (general_input_pin && input_pin_function_field
                       == sprsc_pkg::PIN_FUNC_PULSE_REQ)
                    || serial_pulse_request || sync_eff;

    // timer, sync and request flops
    always_ff @(posedge clk) begin
        if (reset) begin
            timer_cnt            <= sprsc_pkg::TIMER_RESET_VALUE;
            sync_level           <= 1'b0;
            sync_retimed         <= 1'b0;
            pulse_request_status <= 1'b0;
        end else begin
            timer_cnt            <= next_timer_cnt;
            sync_level           <= sync_pin
                                  ^ sync_ctrl[sprsc_pkg::SYNC_POLARITY_BIT];
            sync_retimed         <= next_sync_retimed;
            pulse_request_status <= next_req;
        end
    end

    // ******************************************************
    // pulse generator
    // ******************************************************
    sprsc_pkg::sprsc_state_type state;
    sprsc_pkg::sprsc_state_type next_state;
    logic [4:0] pulses_left;      // pulses still owed in a burst
    logic [4:0] next_pulses_left;
    logic       req_prev;         // request of last cycle
    logic       pending;          // burst request waiting for beat
    logic       next_pending;
    logic       burst_mode;       // counted mode selected
    logic       run_now;          // start condition at idle

    assign burst_mode = (pulse_mode != sprsc_pkg::MODE_LEVEL)
                     && (pulse_mode != sprsc_pkg::MODE_CONTINUOUS);

    // next state on each beat
    always_comb begin
        next_state       = state;
        next_pulses_left = pulses_left;
        next_pending     = pending;
        run_now          = 1'b0;
        case (pulse_mode)
            sprsc_pkg::MODE_LEVEL:      run_now = pulse_request_status;
            sprsc_pkg::MODE_CONTINUOUS: run_now = 1'b1;
            default:                    run_now = pending;
        endcase
        if (beat) begin
            case (state)
                sprsc_pkg::SPRSC_IDLE: begin
                    if (run_now) begin
                        next_state       = sprsc_pkg::SPRSC_HIGH;
                        next_pulses_left = sprsc_pkg::burst_len(pulse_mode);
                        next_pending     = 1'b0;
                    end
                end
                sprsc_pkg::SPRSC_HIGH: begin
                    next_state = sprsc_pkg::SPRSC_LOW;
                    if (pulses_left != 5'h00) begin
                        next_pulses_left = pulses_left - 5'h01;
                    end
                end
                sprsc_pkg::SPRSC_LOW: begin
                    if (pulse_mode == sprsc_pkg::MODE_CONTINUOUS) begin
                        next_state = sprsc_pkg::SPRSC_HIGH;
                    end else if (pulse_mode == sprsc_pkg::MODE_LEVEL) begin
                        next_state = pulse_request_status
                                   ? sprsc_pkg::SPRSC_HIGH
                                   : sprsc_pkg::SPRSC_IDLE;
                    end else begin
                        next_state = (pulses_left != 5'h00)
                                   ? sprsc_pkg::SPRSC_HIGH
                                   : sprsc_pkg::SPRSC_IDLE;
                    end
                end
                default: begin
                    next_state = sprsc_pkg::SPRSC_IDLE;
                end
            endcase
        end
        // new request edge wins over the clear
        if (burst_mode && pulse_request_status && !req_prev) begin
            next_pending = 1'b1;
        end
    end

    // generator flops
    always_ff @(posedge clk) begin
        if (reset) begin
            state       <= sprsc_pkg::SPRSC_IDLE;
            pulses_left <= 5'h00;
            pending     <= 1'b0;
            req_prev    <= 1'b0;
            sysref_out  <= 1'b0;
        end else begin
            state       <= next_state;
            pulses_left <= next_pulses_left;
            pending     <= next_pending;
            req_prev    <= pulse_request_status;
            sysref_out  <= (next_state == sprsc_pkg::SPRSC_HIGH);
        end
    end

    // ******************************************************
    // assertions
    // ******************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_low_beat;
        state == sprsc_pkg::SPRSC_LOW && beat;
    endsequence

    sequence s_two_ticks_div;
        clock_ctrl[sprsc_pkg::INPUT_DIV2_BIT] [*2];
    endsequence

    a_readback_off: assert property (
        !readback_ctrl[sprsc_pkg::READBACK_ENABLE_BIT]
        |=> !serial_readback_line_oe)
        else $error("readback driver on while disabled");
    a_open_drain_low: assert property (
        !readback_ctrl[sprsc_pkg::READBACK_MODE_BIT]
        |=> !serial_readback_line_out)
        else $error("open drain drove high");
    a_level_stop: assert property (
        s_low_beat ##0 (pulse_mode == sprsc_pkg::MODE_LEVEL)
        ##0 !pulse_request_status |=> !sysref_out
        && state == sprsc_pkg::SPRSC_IDLE)
        else $error("level mode kept running");
    a_burst_load: assert property (
        state == sprsc_pkg::SPRSC_IDLE && beat && burst_mode && pending
        |=> sysref_out && pulses_left ==
            sprsc_pkg::burst_len($past(pulse_mode)))
        else $error("burst length wrong");
    a_cont_duty: assert property (
        s_low_beat ##0 (pulse_mode == sprsc_pkg::MODE_CONTINUOUS)
        |=> sysref_out)
        else $error("continuous mode missed a pulse");
    a_sync_hold: assert property (
        !beat |=> $stable(sync_retimed))
        else $error("retimed sync moved off beat");
    a_sync_polarity: assert property (
        ##1 sync_level == ($past(sync_pin)
        ^ $past(sync_ctrl[sprsc_pkg::SYNC_POLARITY_BIT])))
        else $error("sync polarity wrong");
    a_timer_reload: assert property (
        beat |=> timer_cnt == $past(timer_setpoint))
        else $error("timer did not reload");
    a_div_tick: assert property (
        s_two_ticks_div |-> (tick != $past(tick)))
        else $error("divided rate not halved");
    a_low_power_wr: assert property (
        reg_write && addr == sprsc_pkg::DELAY_POWER_CTRL_ADDR
        |=> analog_delay_low_power == $past(reg_wdata[0]))
        else $error("low power bit not stored");
    a_pin_request: assert property (
        general_input_pin
        && input_pin_function_field == sprsc_pkg::PIN_FUNC_PULSE_REQ
        |=> pulse_request_status)
        else $error("pin request lost");
    a_burst_idle: assert property (
        s_low_beat ##0 burst_mode ##0 (pulses_left == 5'h00) ##0 !pending
        |=> state == sprsc_pkg::SPRSC_IDLE ##1
            (state == sprsc_pkg::SPRSC_IDLE || $past(pending)))
        else $error("burst did not return to idle");

endmodule : sprsc_core

`default_nettype wire

// file: bench/sprsc_host.sv
`timescale 1ns/10ps
`default_nettype none
// host model: one-cycle register strobes, launched on rising edges
module sprsc_host #(
    parameter logic [11:0] SETPOINT = 12'h009
) (
    input  wire logic        clk,
    output var  logic [11:0] reg_addr,
    output var  logic        reg_write,
    output var  logic        reg_read,
    output var  logic [7:0]  reg_wdata
);
    // idle bus at time zero
    initial begin
        reg_addr = 12'h000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end
    // write one byte, strobe stands for one edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    // read one byte, answer is watched by the bench
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
    endtask : rd
    // beat at most 4 MHz: setpoint 9 gives 40/10 MHz
    task automatic init_timer();
        wr(sprsc_pkg::MASTER_TIMER_LOW_ADDR, SETPOINT[7:0]);
        wr(sprsc_pkg::MASTER_TIMER_HIGH_ADDR, {4'h0, SETPOINT[11:8]});
        wr(sprsc_pkg::EXT_SYNC_CTRL_ADDR, 8'h00);
    endtask : init_timer
endmodule : sprsc_host
`default_nettype wire

// file: bench/sysref_pulse_sync_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sysref_pulse_sync_control_tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [11:0] addr;
    logic [7:0]  wdata, rdata, d, rexp;
    logic        wr_en, rd_en, rvalid, rb_act, rb_bit, rb_out, rb_oe;
    logic        gpin, sreq, sync_pin, sysref, req_st, div2, bias, dlp;
    logic [3:0]  pfunc;
    logic        sr_q = 1'b0;
    logic [7:0]  expq[$];
    int          num_errors = 0;
    int          comparisons = 0;
    int          pulses, highs;
    int          cnt[6] = '{1, 2, 4, 8, 16, 16};
    logic [7:0]  mask[7] = '{8'h03, 8'h07, 8'h05, 8'hFF, 8'h0F, 8'h03, 8'h01};
    logic [11:0] amap[7] = '{12'h054, 12'h05A, 12'h05B, 12'h05C, 12'h05D,
                             12'h064, 12'h065};

    // 40 MHz clock
    always #12.5 clk = ~clk;

    sprsc_host u_host (.clk(clk), .reg_addr(addr), .reg_write(wr_en),
                       .reg_read(rd_en), .reg_wdata(wdata));

    sprsc_core u_dut (
        .clk                      (clk),
        .reset                    (reset),
        .reg_addr                 (addr),
        .reg_write                (wr_en),
        .reg_read                 (rd_en),
        .reg_wdata                (wdata),
        .reg_rdata                (rdata),
        .reg_rvalid               (rvalid),
        .readback_active          (rb_act),
        .readback_bit             (rb_bit),
        .serial_readback_line_out (rb_out),
        .serial_readback_line_oe  (rb_oe),
        .general_input_pin        (gpin),
        .input_pin_function_field (pfunc),
        .serial_pulse_request     (sreq),
        .sync_pin                 (sync_pin),
        .sysref_out               (sysref),
        .pulse_request_status     (req_st),
        .input_div2_enable        (div2),
        .low_freq_bias            (bias),
        .analog_delay_low_power   (dlp)
    );

    // compare and count
    task automatic check(input string what, input logic [7:0] e,
                         input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // read answers are matched against the oldest note
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            rexp = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
            check("read data", rexp, rdata);
        end
    end

    // pulse and high-cycle counter, sampled mid-cycle
    always @(negedge clk) begin
        if (sysref === 1'b1) begin
            highs++;
            if (sr_q !== 1'b1)
                pulses++;
        end
        sr_q = sysref;
    end

    // request held well past the burst: no second burst may follow
    task automatic burst(input logic [2:0] m, input int n, input int per);
        u_host.wr(sprsc_pkg::PULSE_BURST_MODE_ADDR, {5'h00, m});
        repeat (3) @(posedge clk);
        pulses = 0;
        highs = 0;
        sreq <= 1'b1;
        repeat (n * per * 2 + 40) @(posedge clk);
        sreq <= 1'b0;
        @(posedge clk);
        check("burst pulses", 8'(n), 8'(pulses));
        check("burst highs", 8'(n * per), 8'(highs));
    endtask : burst

    task automatic count_win(input int len);
        pulses = 0;
        highs = 0;
        repeat (len) @(posedge clk);
    endtask : count_win

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end

    initial begin
        {rb_act, rb_bit, gpin, sreq, sync_pin} = 5'h00;
        pfunc = 4'h0;
        void'($urandom(68));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            d = 8'($urandom);
            u_host.wr(amap[i], d);
            expq.push_back(d & mask[i]);
            u_host.rd(amap[i]); // stored bits
        end
        u_host.wr(12'h055, 8'hFF);
        expq.push_back(8'h00);
        u_host.rd(12'h055);
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            expq.push_back(8'h00);
            u_host.rd(amap[i]); // cleared by reset
        end
        u_host.init_timer();
        for (int k = 0; k < 4; k++) begin
            u_host.wr(amap[0], {6'h00, k[1], 1'b1});
            rb_act <= 1'b1;
            rb_bit <= k[0];
            repeat (3) @(posedge clk);
            #1;
            check("readback oe", {7'h00, k[1] | ~k[0]}, {7'h00, rb_oe});
            check("readback out", {7'h00, k[1] & k[0]}, {7'h00, rb_out});
        end
        @(posedge clk);
        rb_act <= 1'b0;
        for (int m = 1; m < 7; m++)
            burst(3'(m), cnt[m - 1], 10);
        u_host.wr(sprsc_pkg::INPUT_CLOCK_CTRL_ADDR, 8'h02);
        @(posedge clk);
        #1;
        check("div2", 8'h01, {7'h00, div2});
        burst(3'h1, 1, 20); // halved beat
        u_host.wr(sprsc_pkg::INPUT_CLOCK_CTRL_ADDR, 8'h01);
        u_host.wr(sprsc_pkg::DELAY_POWER_CTRL_ADDR, 8'h01);
        @(posedge clk);
        #1;
        check("div2 off", 8'h00, {7'h00, div2});
        check("bias", 8'h01, {7'h00, bias});
        check("low power", 8'h01, {7'h00, dlp});
        u_host.wr(sprsc_pkg::PULSE_BURST_MODE_ADDR, 8'h01);
        pulses = 0;
        highs = 0;
        u_host.wr(sprsc_pkg::EXT_SYNC_CTRL_ADDR, 8'h05);
        repeat (100) @(posedge clk);
        check("sync pulses", 8'h01, 8'(pulses));
        u_host.wr(sprsc_pkg::EXT_SYNC_CTRL_ADDR, 8'h00);
        repeat (3) @(posedge clk);
        pulses = 0;
        sync_pin <= 1'b1;
        repeat (60) @(posedge clk);
        check("bypass pulses", 8'h01, 8'(pulses));
        sync_pin <= 1'b0;
        u_host.wr(sprsc_pkg::PULSE_BURST_MODE_ADDR, 8'h00);
        pfunc <= 4'h4;
        gpin <= 1'b1;
        count_win(95);
        check("request", 8'h01, {7'h00, req_st});
        gpin <= 1'b0;
        repeat (60) @(posedge clk);
        check("level run", 8'h01, {7'h00, pulses > 0});
        check("level highs", 8'(pulses * 10), 8'(highs));
        pfunc <= 4'h3;
        gpin <= 1'b1;
        count_win(80);
        check("request off", 8'h00, {7'h00, req_st});
        gpin <= 1'b0;
        check("pin other", 8'h00, 8'(pulses));
        u_host.wr(sprsc_pkg::PULSE_BURST_MODE_ADDR, 8'h07);
        repeat (30) @(posedge clk);
        count_win(200);
        check("cont pulses", 8'd10, 8'(pulses));
        check("cont highs", 8'd100, 8'(highs));
        repeat (20) @(posedge clk);
        conclude();
    end
endmodule : sysref_pulse_sync_control_tb
`default_nettype wire
